// ---- gtm_cfg.svh ----
// register offsets, field positions and reset values of the gated timer
`ifndef GTM_CFG_SVH
`define GTM_CFG_SVH
`define GTM_ADDR_W        2
`define GTM_OFF_TCTRL     2'h0
`define GTM_OFF_GCTRL     2'h1
`define GTM_OFF_CNT_LO    2'h2
`define GTM_OFF_CNT_HI    2'h3
`define GTM_TCTRL_RST     8'h00
`define GTM_GCTRL_RST     8'h00
`define GTM_CNT_RST       16'h0000
`define GTM_TC_ON         0
`define GTM_TC_SYNC_BYP   2
`define GTM_TC_OSC_EN     3
`define GTM_TC_PRE_LSB    4
`define GTM_TC_CS_LSB     6
`define GTM_GC_GSS_LSB    0
`define GTM_GC_GVAL       2
`define GTM_GC_ARMED      3
`define GTM_GC_SPM        4
`define GTM_GC_TM         5
`define GTM_GC_POL        6
`define GTM_GC_GE         7
`define GTM_TCTRL_WMASK   8'hfd
`define GTM_GCTRL_WMASK   8'hf3
`define GTM_INSTR_DIV     2'h3
`endif

// ---- gtm_pkg.sv ----
// types shared by the gated timer
package gtm_pkg;
   typedef enum logic [1:0] {
      GTM_CS_INSTR = 2'h0,
      GTM_CS_SYS   = 2'h1,
      GTM_CS_EXT   = 2'h2,
      GTM_CS_RSVD  = 2'h3
   } gtm_cs_e;

   typedef enum logic [2:0] {
      GTM_SP_IDLE  = 3'h1,
      GTM_SP_WAIT  = 3'h2,
      GTM_SP_ACT   = 3'h4
   } gtm_sp_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [1:0] addr;
      logic [7:0] wdata;
   } gtm_bus_s;

   typedef struct packed {
      logic gate_pin;
      logic sib_ovf;
      logic cmp1;
      logic cmp2;
   } gtm_gsrc_s;
endpackage

// ---- gtm_timer.sv ----
// gated 16-bit timer with clock select, prescaler, gate logic and register port
`timescale 1ns/10ps
`default_nettype none
`include "gtm_cfg.svh"

module gtm_timer #(
   parameter int CNT_W = 16
) (
   input  wire logic              clk_i,
   input  wire logic              resetn_i,
   input  wire gtm_pkg::gtm_bus_s bus_i,
   output logic [7:0]             rdata_o,
   input  wire gtm_pkg::gtm_gsrc_s gsrc_i,
   input  wire logic              ext_clk_i,
   input  wire logic              sosc_clk_i,
   input  wire logic              cmp_sync_en_i,
   input  wire logic              adc_trig_i,
   output logic                   sosc_en_o,
   output logic                   overflow_flag_o,
   output logic                   gate_event_flag_o,
   output logic [CNT_W-1:0]       count_o
);
   import gtm_pkg::*;

   // stored state, plus the combinational next count
   logic [7:0]       tctrl_q;
   logic [7:0]       gctrl_q;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [1:0]       idiv_q;
   logic [2:0]       pre_q;
   logic             ext_s1_q;
   logic             ext_s2_q;
   logic             ext_prev_q;
   logic             fall_seen_q;
   logic             cmp_s1_q [2];
   logic             cmp_s2_q [2];
   logic             sib_prev_q;
   logic             graw_prev_q;
   logic             tog_q;
   logic             gval_q;
   logic             gval_prev_q;
   gtm_sp_e          sp_q;
   logic             ovf_q;
   logic             gev_q;
   logic [7:0]       rdata_q;

   // decoded and combinational signals
   logic             timer_on;
   logic             wr_lo;
   logic             wr_hi;
   logic             ext_lvl;
   logic             src_tick;
   logic             pre_tick;
   logic             gate_raw;
   logic             gate_pol;
   logic             gate_lvl;
   logic             gate_ok;
   logic             inc;
   logic [2:0]       pre_mask;
   logic             wrap;
   logic             cmp_raw  [2];

   // true when a bus write hits the given offset
   function automatic logic hit(input gtm_bus_s b, input logic [1:0] off);
      hit = b.wr && (b.addr == off);
   endfunction

   assign timer_on = tctrl_q[`GTM_TC_ON];
   assign wr_lo    = hit(bus_i, `GTM_OFF_CNT_LO);
   assign wr_hi    = hit(bus_i, `GTM_OFF_CNT_HI);

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tctrl_q <= `GTM_TCTRL_RST;
      end else if (hit(bus_i, `GTM_OFF_TCTRL)) begin
         tctrl_q <= bus_i.wdata & `GTM_TCTRL_WMASK;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gctrl_q <= `GTM_GCTRL_RST;
      end else begin
         gctrl_q[7:4] <= hit(bus_i, `GTM_OFF_GCTRL) ? bus_i.wdata[7:4] : gctrl_q[7:4];
         gctrl_q[1:0] <= hit(bus_i, `GTM_OFF_GCTRL) ? bus_i.wdata[1:0] : gctrl_q[1:0];
         gctrl_q[2]   <= 1'b0;
         if (hit(bus_i, `GTM_OFF_GCTRL)) begin
            gctrl_q[`GTM_GC_ARMED] <= bus_i.wdata[`GTM_GC_ARMED];
         end else if (sp_q == GTM_SP_ACT && !gate_lvl) begin
            gctrl_q[`GTM_GC_ARMED] <= 1'b0;
         end
      end
   end

   // external clock synchronizer
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
      end else begin
         ext_s1_q <= tctrl_q[`GTM_TC_OSC_EN] ? sosc_clk_i : ext_clk_i;
         ext_s2_q <= ext_s1_q;
      end
   end

   // previous clock level for edge detection
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ext_prev_q <= 1'b0;
      end else begin
         ext_prev_q <= ext_lvl;
      end
   end

   // bypass uses the raw level, sampled once
   assign ext_lvl = tctrl_q[`GTM_TC_SYNC_BYP] ?
                    (tctrl_q[`GTM_TC_OSC_EN] ? sosc_clk_i : ext_clk_i) : ext_s2_q;

   // falling edge seen since external counting began
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fall_seen_q <= 1'b0;
      end else if (!timer_on || tctrl_q[7:6] != GTM_CS_EXT) begin
         fall_seen_q <= 1'b0;
      end else if (ext_prev_q && !ext_lvl) begin
         fall_seen_q <= 1'b1;
      end
   end

   // instruction clock divider, free running
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         idiv_q <= 2'h0;
      end else begin
         idiv_q <= idiv_q + 2'h1;
      end
   end

   always_comb begin
      case (gtm_cs_e'(tctrl_q[7:6]))
         GTM_CS_INSTR: src_tick = (idiv_q == `GTM_INSTR_DIV);
         GTM_CS_SYS:   src_tick = 1'b1;
         GTM_CS_EXT:   src_tick = !ext_prev_q && ext_lvl && fall_seen_q;
         default:      src_tick = 1'b0;
      endcase
   end

   always_comb begin
      case (tctrl_q[5:4])
         2'h0:    pre_mask = 3'h0;
         2'h1:    pre_mask = 3'h1;
         2'h2:    pre_mask = 3'h3;
         default: pre_mask = 3'h7;
      endcase
   end

   // tick passes when the masked prescaler bits are all ones
   assign pre_tick = src_tick && ((pre_q & pre_mask) == pre_mask);

   // prescaler count, restarts while off
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pre_q <= 3'h0;
      end else if (!timer_on) begin
         pre_q <= 3'h0;
      end else if (src_tick) begin
         pre_q <= pre_q + 3'h1;
      end
   end

   // comparator synchronizers, one stage pair per comparator
   assign cmp_raw[0] = gsrc_i.cmp1;
   assign cmp_raw[1] = gsrc_i.cmp2;

   for (genvar g = 0; g < 2; g++) begin : g_cmp_sync
      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            cmp_s1_q[g] <= 1'b0;
            cmp_s2_q[g] <= 1'b0;
         end else begin
            cmp_s1_q[g] <= cmp_raw[g];
            cmp_s2_q[g] <= cmp_s1_q[g];
         end
      end
   end

   // sibling wrap edge detector
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sib_prev_q <= 1'b0;
      end else begin
         sib_prev_q <= gsrc_i.sib_ovf;
      end
   end

   always_comb begin
      case (gctrl_q[1:0])
         2'h0:    gate_raw = gsrc_i.gate_pin;
         2'h1:    gate_raw = gsrc_i.sib_ovf && !sib_prev_q;
         2'h2:    gate_raw = cmp_sync_en_i ? cmp_s2_q[0] : gsrc_i.cmp1;
         default: gate_raw = cmp_sync_en_i ? cmp_s2_q[1] : gsrc_i.cmp2;
      endcase
   end

   // polarity applied before toggle, status and single pulse
   assign gate_pol = gctrl_q[`GTM_GC_POL] ? gate_raw : !gate_raw;

   // previous polarized gate level for edge detection
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         graw_prev_q <= 1'b0;
      end else begin
         graw_prev_q <= gate_pol;
      end
   end

   // toggle flip-flop on rising edges of the polarized gate
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tog_q <= 1'b0;
      end else if (!gctrl_q[`GTM_GC_TM] || !timer_on) begin
         tog_q <= 1'b0;
      end else if (gate_pol && !graw_prev_q) begin
         tog_q <= !tog_q;
      end
   end

   // toggle output replaces the gate level in toggle mode
   assign gate_lvl = gctrl_q[`GTM_GC_TM] ? tog_q : gate_pol;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sp_q <= GTM_SP_IDLE;
      end else begin
         case (sp_q)
            GTM_SP_IDLE: if (gctrl_q[`GTM_GC_SPM] && gctrl_q[`GTM_GC_ARMED]) begin
               sp_q <= GTM_SP_WAIT;
            end
            GTM_SP_WAIT: if (!gctrl_q[`GTM_GC_SPM] || !gctrl_q[`GTM_GC_ARMED]) begin
               sp_q <= GTM_SP_IDLE;
            end else if (gate_lvl) begin
               sp_q <= GTM_SP_ACT;
            end
            GTM_SP_ACT: if (!gate_lvl || !gctrl_q[`GTM_GC_SPM]) begin
               sp_q <= GTM_SP_IDLE;
            end
            default: sp_q <= GTM_SP_IDLE;
         endcase
      end
   end

   always_comb begin
      if (!gctrl_q[`GTM_GC_GE]) begin
         gate_ok = 1'b1;
      end else if (gctrl_q[`GTM_GC_SPM]) begin
         gate_ok = (sp_q == GTM_SP_ACT) && gate_lvl;
      end else begin
         gate_ok = gate_lvl;
      end
   end

   // one count per prescaled tick while on and the gate permits
   assign inc = timer_on && gate_ok && pre_tick;

   // count update: write beats trigger beats increment
   always_comb begin
      cnt_d = cnt_q;
      if (adc_trig_i) begin
         cnt_d = `GTM_CNT_RST;
      end else if (inc) begin
         cnt_d = cnt_q + 16'h0001;
      end
      if (wr_lo) begin
         cnt_d[7:0] = bus_i.wdata;
      end
      if (wr_hi) begin
         cnt_d[15:8] = bus_i.wdata;
      end
   end

   // count register
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_q <= `GTM_CNT_RST;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // gate level status, live whatever gate enable says
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gval_q      <= 1'b0;
         gval_prev_q <= 1'b0;
      end else begin
         gval_q      <= gate_lvl;
         gval_prev_q <= gval_q;
      end
   end

   // rollover by increment only; trigger clear or byte write never flags
   assign wrap = inc && (cnt_q == 16'hffff);

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ovf_q <= 1'b0;
      end else begin
         ovf_q <= wrap && !adc_trig_i && !wr_lo && !wr_hi;
      end
   end

   // one-cycle pulse on a falling gate level status
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gev_q <= 1'b0;
      end else begin
         gev_q <= gval_prev_q && !gval_q;
      end
   end

   // readback, one cycle after the read strobe
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_q <= 8'h00;
      end else if (bus_i.rd) begin
         case (bus_i.addr)
            `GTM_OFF_TCTRL:  rdata_q <= tctrl_q;
            `GTM_OFF_GCTRL:  rdata_q <= {gctrl_q[7:3], gval_q, gctrl_q[1:0]};
            `GTM_OFF_CNT_LO: rdata_q <= cnt_q[7:0];
            default:         rdata_q <= cnt_q[15:8];
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // outputs straight from registers
   assign rdata_o           = rdata_q;
   assign sosc_en_o         = tctrl_q[`GTM_TC_OSC_EN];
   assign overflow_flag_o   = ovf_q;
   assign gate_event_flag_o = gev_q;
   assign count_o           = cnt_q;
endmodule
`default_nettype wire

// ---- gtm_sva.sv ----
// assertion checker for the gated timer ports
`timescale 1ns/10ps
`default_nettype none
`include "gtm_cfg.svh"
module gtm_sva #(
   parameter int CNT_W = 16
) (
   input wire logic              clk_i,
   input wire logic              resetn_i,
   input wire gtm_pkg::gtm_bus_s bus_i,
   input wire logic              adc_trig_i,
   input wire logic              sosc_en_o,
   input wire logic              overflow_flag_o,
   input wire logic              gate_event_flag_o,
   input wire logic [CNT_W-1:0]  count_o
);
   import gtm_pkg::*;
   logic [7:0] ctl_q;
   logic       ge_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // shadow of control register and gate enable
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctl_q <= 8'h00;
         ge_q  <= 1'b0;
      end else if (bus_i.wr && bus_i.addr == `GTM_OFF_TCTRL) begin
         ctl_q <= bus_i.wdata & `GTM_TCTRL_WMASK;
      end else if (bus_i.wr && bus_i.addr == `GTM_OFF_GCTRL) begin
         ge_q <= bus_i.wdata[`GTM_GC_GE];
      end
   end
   AST_TRIG_CLR: assert property (adc_trig_i && !bus_i.wr |=> count_o == '0)
      else $error("trigger did not clear the count");
   AST_TRIG_NO_OVF: assert property (adc_trig_i |=> !overflow_flag_o)
      else $error("trigger clear raised overflow");
   AST_WR_WINS: assert property (adc_trig_i && bus_i.wr && bus_i.addr == `GTM_OFF_CNT_LO
      |=> count_o == {8'h00, $past(bus_i.wdata)})
      else $error("count write lost to trigger");
   AST_OSC_EN: assert property (sosc_en_o == ctl_q[3])
      else $error("oscillator enable differs from control");
   AST_OFF_HOLD: assert property (!ctl_q[0] && !adc_trig_i && !bus_i.wr
      |=> $stable(count_o))
      else $error("count moved while off");
   AST_SYS_CNT: assert property (ctl_q == 8'h41 && $past(ctl_q) == 8'h41 && !ge_q
      && !adc_trig_i && !bus_i.wr && !$past(bus_i.wr) |=> count_o == $past(count_o) + 1'b1)
      else $error("system clock count step wrong");
   AST_OVF: assert property (overflow_flag_o |-> count_o == '0 ##1 !overflow_flag_o)
      else $error("overflow pulse wrong");
   AST_GEV: assert property (gate_event_flag_o |=> !gate_event_flag_o)
      else $error("gate event pulse too long");
   COV_TRIG_WR: cover property (adc_trig_i && bus_i.wr);
   COV_OVF: cover property (overflow_flag_o);
   COV_GEV: cover property (gate_event_flag_o);
endmodule
bind gtm_timer gtm_sva #(.CNT_W(CNT_W)) i_gtm_sva (.clk_i, .resetn_i, .bus_i, .adc_trig_i,
   .sosc_en_o, .overflow_flag_o, .gate_event_flag_o, .count_o);
`default_nettype wire

// ---- gtm_far.sv ----
// far-side model: compare trigger, pin clocks, sibling timer
`timescale 1ns/10ps
`default_nettype none
module gtm_far (
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic [15:0] count_i,
   input  wire logic [15:0] cmp_val_i,
   input  wire logic        trig_en_i,
   output logic             adc_trig_o,
   output logic             ext_clk_o,
   output logic             sosc_clk_o,
   output logic             sib_ovf_o
);
   logic [7:0] div_q;
   // match fires the clear, so compare value sets the period
   assign adc_trig_o = trig_en_i && count_i == cmp_val_i;
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) div_q <= 8'h00;
      else div_q <= div_q + 8'h01;
   end
   // pin clock 8 cycles, oscillator 16, sibling wraps every 256
   assign ext_clk_o  = div_q[2];
   assign sosc_clk_o = div_q[3];
   assign sib_ovf_o  = div_q == 8'hff;
endmodule
`default_nettype wire

// ---- test_gated_16bit_timer_control.sv ----
// self-checking bench of the gated timer
`timescale 1ns/10ps
`default_nettype none
module test_gated_16bit_timer_control;
   import gtm_pkg::*;
   logic        clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   gtm_bus_s    bus = '0;
   gtm_gsrc_s   gs = '0;
   gtm_gsrc_s   gsrc;
   logic        cse = 1'b0;
   logic        ten = 1'b0;
   logic [15:0] cmp = 16'h0000;
   logic [7:0]  rdata, r;
   logic        trig, ext, sosc, sib, sen, ovf, gev, lv;
   logic [15:0] cnt, maxc, a, b;
   int          fail_count = 0, cmp_count = 0, cyc = 0, ovf_n = 0, gev_n = 0, n;
   logic [7:0]  rates [13] = '{8'h01, 8'h11, 8'h31, 8'h41, 8'h51, 8'h61, 8'h71, 8'h81,
      8'hb1, 8'h85, 8'h89, 8'hc1, 8'h40};
   always_comb begin
      gsrc = gs;
      gsrc.sib_ovf = sib;
   end
   gtm_timer i_gtm_timer (.clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus), .rdata_o(rdata),
      .gsrc_i(gsrc), .ext_clk_i(ext), .sosc_clk_i(sosc), .cmp_sync_en_i(cse),
      .adc_trig_i(trig), .sosc_en_o(sen), .overflow_flag_o(ovf), .gate_event_flag_o(gev),
      .count_o(cnt));
   gtm_far i_gtm_far (.clk_i(clk_i), .resetn_i(resetn_i), .count_i(cnt), .cmp_val_i(cmp),
      .trig_en_i(ten), .adc_trig_o(trig), .ext_clk_o(ext), .sosc_clk_o(sosc), .sib_ovf_o(sib));
   initial forever #50 clk_i = ~clk_i;
   task automatic finish_test();
      $display("mismatches %0d of %0d compares", fail_count, cmp_count);
      if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (ovf === 1'b1) ovf_n++;
      if (gev === 1'b1) gev_n++;
      if (ten && cnt > maxc) maxc = cnt;
      if (cyc == 8000) begin
         fail_count++;
         finish_test();
      end
   end
   task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [1:0] ad, input logic [7:0] d);
      @(posedge clk_i);
      bus.wr <= 1'b1;
      bus.addr <= ad;
      bus.wdata <= d;
      @(posedge clk_i);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] ad, output logic [7:0] q);
      @(posedge clk_i);
      bus.rd <= 1'b1;
      bus.addr <= ad;
      @(posedge clk_i);
      bus.rd <= 1'b0;
      @(negedge clk_i);
      q = rdata;
   endtask
   // count gained over 64 cycles after settling
   task automatic meas(output logic [15:0] d);
      repeat (16) @(negedge clk_i);
      a = cnt;
      repeat (64) @(negedge clk_i);
      d = cnt - a;
   endtask
   function automatic logic [15:0] exp_cnt(input logic [7:0] c);
      logic [15:0] base;
      case (c[7:6])
         2'h0: base = 16'h0010;
         2'h1: base = 16'h0040;
         2'h2: base = c[3] ? 16'h0004 : 16'h0008;
         default: base = 16'h0000;
      endcase
      return c[0] ? base >> c[5:4] : 16'h0000;
   endfunction
   initial begin
      void'($urandom(32'h69269551));
      repeat (3) @(posedge clk_i);
      resetn_i <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd(2'(i), r);
         check("reset value", 16'(r), (i == 1) ? 16'h0004 : 16'h0000);
      end
      wr(2'h0, 8'hff);
      rd(2'h0, r);
      check("control bit 1", 16'(r), 16'h00fd);
      wr(2'h0, 8'h00);
      b = 16'($urandom);
      wr(2'h2, b[7:0]);
      wr(2'h3, b[15:8]);
      rd(2'h2, r);
      check("count low", 16'(r), 16'(b[7:0]));
      rd(2'h3, r);
      check("count high", 16'(r), 16'(b[15:8]));
      foreach (rates[i]) begin
         wr(2'h0, rates[i]);
         meas(b);
         check("count rate", b, exp_cnt(rates[i]));
         check("osc enable", 16'(sen), 16'(rates[i][3]));
      end
      wr(2'h0, 8'h41);
      for (int i = 0; i < 6; i++) begin
         n = (i % 3 == 0) ? 0 : i % 3 + 1;
         gs <= 4'($urandom);
         cse <= 1'($urandom);
         r = {1'b1, 1'($urandom), 4'h0, 2'(n)};
         wr(2'h1, r);
         meas(b);
         lv = (n == 0) ? gs.gate_pin : (n == 2) ? gs.cmp1 : gs.cmp2;
         check("gated count", b, (lv == r[6]) ? 16'h0040 : 16'h0000);
      end
      wr(2'h1, 8'h40);
      gs <= '{gate_pin: 1'b1, default: 1'b0};
      repeat (8) @(negedge clk_i);
      n = gev_n;
      gs.gate_pin <= 1'b0;
      repeat (8) @(negedge clk_i);
      check("gate events", 16'(gev_n - n), 16'h0001);
      wr(2'h1, 8'hd0);
      wr(2'h1, 8'hd8);
      rd(2'h1, r);
      check("armed", 16'(r[3]), 16'h0001);
      a = cnt;
      for (int k = 0; k < 2; k++) begin
         gs.gate_pin <= 1'b1;
         repeat (16) @(negedge clk_i);
         gs.gate_pin <= 1'b0;
         repeat (16) @(negedge clk_i);
         if (k == 0) b = cnt;
      end
      check("second pulse", cnt - b, 16'h0000);
      check("first pulse", 16'(b - a > 16'h000c && b - a < 16'h0014), 16'h0001);
      rd(2'h1, r);
      check("armed done", 16'(r[3]), 16'h0000);
      wr(2'h1, 8'he0);
      @(negedge clk_i);
      a = cnt;
      for (int k = 0; k < 4; k++) begin
         gs.gate_pin <= !k[0];
         repeat (8) @(negedge clk_i);
      end
      check("toggle count", cnt - a, 16'h0010);
      wr(2'h1, 8'he1);
      @(negedge clk_i);
      a = cnt;
      repeat (512) @(negedge clk_i);
      check("sibling toggle", cnt - a, 16'h0100);
      wr(2'h0, 8'h00);
      wr(2'h1, 8'h00);
      wr(2'h2, 8'h00);
      wr(2'h3, 8'h00);
      cmp <= 16'h0010 + 16'($urandom % 32);
      ten <= 1'b1;
      maxc = 16'h0000;
      n = ovf_n;
      wr(2'h0, 8'h01);
      repeat (300) @(negedge clk_i);
      check("period max", maxc, cmp);
      wr(2'h0, 8'h41);
      do @(negedge clk_i); while (cnt !== cmp - 16'h0001);
      wr(2'h2, 8'h5a);
      @(negedge clk_i);
      check("write wins", cnt, 16'h005a);
      check("trigger overflow", 16'(ovf_n - n), 16'h0000);
      ten <= 1'b0;
      wr(2'h0, 8'h00);
      wr(2'h3, 8'hff);
      wr(2'h2, 8'hf0);
      n = ovf_n;
      wr(2'h0, 8'h41);
      repeat (40) @(negedge clk_i);
      check("overflow", 16'(ovf_n - n), 16'h0001);
      finish_test();
   end
endmodule
`default_nettype wire
